// ==== hw/rpc_pkg.sv ====
// Contract
// [R1] Four pacing-disable bits in the control register each turn pacing off for one port and reset to one.
// [R2] Control bits 16 to 19 disable read spreading per port when one and reset to zero.
// [R3] Spreading is active for a port only while pacing is enabled for that port.
// [R4] Software must never enable source queuing and read pacing together.
// [R5] Threshold one bits 12:0 hold the sixteen-lane limit in doublewords, default 800h.
// [R6] Threshold one bits 28:16 hold the eight-lane limit in doublewords, default 600h.
// [R7] Threshold two bits 12:0 hold the four-lane limit in doublewords, default 400h.
// [R8] Each port keeps an outstanding-read counter that counts up per read while not being reset.
// [R9] Writing one to threshold two bits 16 to 19 clears that port's counter, and the bits read zero.
// [R10] After a requester or completer error without system reset software clears the counter.
// [R11] The 4-bit response time field gives off for 0, codes 1 to 9 pick 5 ms to 2 s, default 1.
// [R12] The pacing registers live in port 3 if upstream, else port 1 if upstream, else NT, else 0.
// [R13] The captured bus number in bits 7:0 resets to 00h and is writable only with override set.
// [R14] The captured device number in bits 12:8 is writable on upstream only, read-only downstream.
// [R15] Override bit 31 resets to zero and when set allows bus and device numbers to be written.
// [R16] Software should leave the captured numbers at their defaults.
// [R17] With pacing on, reads hold while the counter is at or above the width threshold.
package rpc_pkg;
  localparam int PORTS = 4;
  localparam logic [11:0] OFF_CTRL = 12'h01d0;
  localparam logic [11:0] OFF_THR1 = 12'h01d4;
  localparam logic [11:0] OFF_THR2 = 12'h01d8;
  localparam logic [11:0] OFF_CAP = 12'h01dc;
  localparam int PACE_DIS_LSB = 0;
  localparam int SPREAD_DIS_LSB = 16;
  localparam int CNT_CLR_LSB = 16;
  localparam int RSP_LSB = 24;
  localparam int THR_HI_LSB = 16;
  localparam int DEV_LSB = 8;
  localparam int OVR_BIT = 31;
  localparam logic [3:0] PACE_DIS_RST = 4'hf;
  localparam logic [3:0] SPREAD_DIS_RST = 4'h0;
  localparam logic [12:0] THR_X16_RST = 13'h0800;
  localparam logic [12:0] THR_X8_RST = 13'h0600;
  localparam logic [12:0] THR_X4_RST = 13'h0400;
  localparam logic [3:0] RSP_RST = 4'h1;
  localparam logic [7:0] BUS_RST = 8'h00;
  localparam logic [4:0] DEV_RST = 5'h00;
  localparam logic [2:0] HOME_NT = 3'h4;
  // Link width codes per port
  localparam logic [1:0] WID_X4 = 2'h0;
  localparam logic [1:0] WID_X8 = 2'h1;
  localparam logic [1:0] WID_X16 = 2'h2;
endpackage : rpc_pkg

// ==== hw/rpc_regs.sv ====
`timescale 1ns/1ps
module rpc_regs #(
  parameter int CNT_W = 14
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regWrFromEe,
  input wire logic regRdEn,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [3:0] portUpstreamPin,
  input wire logic port0LegacyNtPin,
  input wire logic selfUpstreamPin,
  input wire logic capLoad,
  input wire logic [7:0] capBus,
  input wire logic [4:0] capDev,
  input wire logic [3:0] rdIssue,
  input wire logic [3:0] cplReturn,
  input wire logic [7:0] linkWidth,
  output logic [31:0] regRdData,
  output logic regRdValid,
  output logic [3:0] rdHold,
  output logic [3:0] spreadEn,
  output logic [2:0] pacingHome,
  output logic rspTimeoutEn,
  output logic [10:0] rspLimitMs
);
  logic [1:0] rstSync_r;
  logic rstSync_n;
  logic [5:0] pinS1_r, pinS2_r;
  logic [3:0] upSync;
  logic ntSync, selfUpSync;
  logic [3:0] paceDis_r, paceDis_nxt, sprDis_r, sprDis_nxt;
  logic [12:0] thr16_r, thr16_nxt, thr8_r, thr8_nxt, thr4_r, thr4_nxt;
  logic [3:0] rsp_r, rsp_nxt, cntClr;
  logic [7:0] bus_r, bus_nxt;
  logic [4:0] dev_r, dev_nxt;
  logic ovr_r, ovr_nxt;
  logic [CNT_W-1:0] cnt_r [rpc_pkg::PORTS], cnt_nxt [rpc_pkg::PORTS];
  logic [3:0] hold_nxt, spr_nxt;
  logic [2:0] home_nxt;
  logic [31:0] rd_nxt;
  logic rspEn_nxt;
  logic [10:0] rspMs_nxt;

  function automatic logic [10:0] rspMs(input logic [3:0] code);
    case (code)
      4'h1: rspMs = 11'd5;
      4'h2: rspMs = 11'd10;
      4'h3: rspMs = 11'd15;
      4'h4: rspMs = 11'd100;
      4'h5: rspMs = 11'd200;
      4'h6: rspMs = 11'd300;
      4'h7: rspMs = 11'd500;
      4'h8: rspMs = 11'd1000;
      4'h9: rspMs = 11'd2000;
      default: rspMs = 11'd0;
    endcase
  endfunction : rspMs

  function automatic logic [12:0] thrFor(input logic [1:0] w, input logic [12:0] t16,
                                         input logic [12:0] t8, input logic [12:0] t4);
    case (w)
      rpc_pkg::WID_X16: thrFor = t16;
      rpc_pkg::WID_X8: thrFor = t8;
      default: thrFor = t4;
    endcase
  endfunction : thrFor

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstSync_r[1];

  // Straps are pins, so they are synchronised before use
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinS1_r <= 6'h00;
      pinS2_r <= 6'h00;
    end else begin
      pinS1_r <= {selfUpstreamPin, port0LegacyNtPin, portUpstreamPin};
      pinS2_r <= pinS1_r;
    end
  end
  assign upSync = pinS2_r[3:0];
  assign ntSync = pinS2_r[4];
  assign selfUpSync = pinS2_r[5];

  // Register file next state
  always_comb begin
    paceDis_nxt = paceDis_r;
    sprDis_nxt = sprDis_r;
    thr16_nxt = thr16_r;
    thr8_nxt = thr8_r;
    thr4_nxt = thr4_r;
    rsp_nxt = rsp_r;
    bus_nxt = bus_r;
    dev_nxt = dev_r;
    ovr_nxt = ovr_r;
    cntClr = 4'h0;
    if (capLoad) begin
      bus_nxt = capBus;
      dev_nxt = capDev;
    end
    if (regWrEn) begin
      case (regAddr)
        rpc_pkg::OFF_CTRL: begin
          paceDis_nxt = regWrData[rpc_pkg::PACE_DIS_LSB +: 4]; // R1
          sprDis_nxt = regWrData[rpc_pkg::SPREAD_DIS_LSB +: 4]; // R2
        end
        rpc_pkg::OFF_THR1: begin
          thr16_nxt = regWrData[12:0]; // R5
          thr8_nxt = regWrData[rpc_pkg::THR_HI_LSB +: 13]; // R6
        end
        rpc_pkg::OFF_THR2: begin
          thr4_nxt = regWrData[12:0]; // R7
          cntClr = regWrData[rpc_pkg::CNT_CLR_LSB +: 4]; // R9
          rsp_nxt = regWrData[rpc_pkg::RSP_LSB +: 4]; // R11
        end
        rpc_pkg::OFF_CAP: begin
          ovr_nxt = regWrData[rpc_pkg::OVR_BIT]; // R15
          // Override must already be set; the same write cannot unlock itself
          if (ovr_r) begin
            bus_nxt = regWrData[7:0]; // R13
          end
          if (ovr_r && selfUpSync) begin
            dev_nxt = regWrData[rpc_pkg::DEV_LSB +: 5]; // R14
          end
        end
        default: begin
        end
      endcase
    end
  end

  // EEPROM loads cannot reach the device number downstream either: same gate
  wire unusedEe = regWrFromEe;

  // Counters, hold and spread
  always_comb begin
    for (int p = 0; p < rpc_pkg::PORTS; p++) begin
      cnt_nxt[p] = cnt_r[p];
      if (cntClr[p]) begin
        cnt_nxt[p] = '0; // R9
      end else if (rdIssue[p] && !cplReturn[p] && !(&cnt_r[p])) begin
        cnt_nxt[p] = cnt_r[p] + 1'b1; // R8
      end else if (cplReturn[p] && !rdIssue[p] && (|cnt_r[p])) begin
        cnt_nxt[p] = cnt_r[p] - 1'b1; // R17
      end
      hold_nxt[p] = !paceDis_nxt[p] && (cnt_nxt[p] >= CNT_W'(thrFor(linkWidth[2*p +: 2],
                    thr16_nxt, thr8_nxt, thr4_nxt))); // R17
      spr_nxt[p] = !paceDis_nxt[p] && !sprDis_nxt[p]; // R3
    end
    if (upSync[3]) begin
      home_nxt = 3'd3; // R12
    end else if (upSync[1]) begin
      home_nxt = 3'd1;
    end else if (ntSync) begin
      home_nxt = rpc_pkg::HOME_NT;
    end else begin
      home_nxt = 3'd0;
    end
    rspEn_nxt = (rspMs(rsp_nxt) != 11'd0); // R11
    rspMs_nxt = rspMs(rsp_nxt);
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (regAddr)
      rpc_pkg::OFF_CTRL: begin
        rd_nxt[rpc_pkg::PACE_DIS_LSB +: 4] = paceDis_r;
        rd_nxt[rpc_pkg::SPREAD_DIS_LSB +: 4] = sprDis_r;
      end
      rpc_pkg::OFF_THR1: begin
        rd_nxt[12:0] = thr16_r;
        rd_nxt[rpc_pkg::THR_HI_LSB +: 13] = thr8_r;
      end
      rpc_pkg::OFF_THR2: begin
        rd_nxt[12:0] = thr4_r; // R9
        rd_nxt[rpc_pkg::RSP_LSB +: 4] = rsp_r;
      end
      rpc_pkg::OFF_CAP: begin
        rd_nxt[7:0] = bus_r;
        rd_nxt[rpc_pkg::DEV_LSB +: 5] = dev_r;
        rd_nxt[rpc_pkg::OVR_BIT] = ovr_r;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      paceDis_r <= rpc_pkg::PACE_DIS_RST; // R1
      sprDis_r <= rpc_pkg::SPREAD_DIS_RST; // R2
      thr16_r <= rpc_pkg::THR_X16_RST;
      thr8_r <= rpc_pkg::THR_X8_RST;
      thr4_r <= rpc_pkg::THR_X4_RST;
      rsp_r <= rpc_pkg::RSP_RST;
      bus_r <= rpc_pkg::BUS_RST;
      dev_r <= rpc_pkg::DEV_RST;
      ovr_r <= 1'b0;
      for (int p = 0; p < rpc_pkg::PORTS; p++) begin
        cnt_r[p] <= '0;
      end
      rdHold <= 4'h0;
      spreadEn <= 4'h0;
      pacingHome <= 3'd0;
      rspTimeoutEn <= 1'b1;
      rspLimitMs <= 11'd5;
      regRdData <= 32'h0000_0000;
      regRdValid <= 1'b0;
    end else begin
      paceDis_r <= paceDis_nxt;
      sprDis_r <= sprDis_nxt;
      thr16_r <= thr16_nxt;
      thr8_r <= thr8_nxt;
      thr4_r <= thr4_nxt;
      rsp_r <= rsp_nxt;
      bus_r <= bus_nxt;
      dev_r <= dev_nxt;
      ovr_r <= ovr_nxt;
      for (int p = 0; p < rpc_pkg::PORTS; p++) begin
        cnt_r[p] <= cnt_nxt[p];
      end
      rdHold <= hold_nxt;
      spreadEn <= spr_nxt;
      pacingHome <= home_nxt;
      rspTimeoutEn <= rspEn_nxt;
      rspLimitMs <= rspMs_nxt;
      regRdData <= rd_nxt;
      regRdValid <= regRdEn;
    end
  end

  chk_spread_gate: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R3
    ##1 (spreadEn & paceDis_r) == 4'h0) else $error("spread active with pacing off");
  chk_pace_off_hold: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R1
    ##1 (rdHold & paceDis_r) == 4'h0) else $error("hold while pacing disabled");
  chk_cnt_clear: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R9
    regWrEn && regAddr == rpc_pkg::OFF_THR2 && regWrData[16] |=> cnt_r[0] == '0)
    else $error("counter not cleared");
  chk_cnt_inc: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R8
    rdIssue[0] && !cplReturn[0] && !cntClr[0] && !(&cnt_r[0])
    |=> cnt_r[0] == $past(cnt_r[0]) + 1'b1) else $error("counter did not count");
  chk_rz_read: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R9
    regRdEn && regAddr == rpc_pkg::OFF_THR2 |=> regRdValid && regRdData[19:16] == 4'h0)
    else $error("reset bits read nonzero");
  chk_bus_lock: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R13
    !ovr_r && !capLoad |=> bus_r == $past(bus_r)) else $error("bus number changed locked");
  chk_dev_ro: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R14
    !selfUpSync && !capLoad |=> dev_r == $past(dev_r)) else $error("downstream dev written");
  chk_home_pick: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R12
    upSync[3] |=> pacingHome == 3'd3) else $error("wrong pacing home");
  chk_rsp_decode: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R11
    rsp_r == 4'h9 |-> rspLimitMs == 11'd2000 && rspTimeoutEn) else $error("bad timeout decode");
  chk_hold_thresh: assert property (@(posedge core_clk) disable iff (!rstSync_n) // R17
    ##1 !paceDis_r[0] && linkWidth[1:0] == rpc_pkg::WID_X4 && $stable(linkWidth)
    && cnt_r[0] >= CNT_W'(thr4_r) |-> rdHold[0]) else $error("hold missed threshold");
endmodule : rpc_regs

// ==== sim/test_read_pacing_control_regs.sv ====
`timescale 1ns/1ps
module test_read_pacing_control_regs;
  logic coreClk = 1'b0;
  logic rstN = 1'b0;
  logic regWrEn = 1'b0, regWrFromEe = 1'b0, regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [3:0] portUpstreamPin = 4'h0;
  logic port0LegacyNtPin = 1'b0, selfUpstreamPin = 1'b0, capLoad = 1'b0;
  logic [7:0] capBus = 8'ha5;
  logic [4:0] capDev = 5'h0a;
  logic [3:0] rdIssue = 4'h0, cplReturn = 4'h0;
  logic [7:0] linkWidth = {2'h0, rpc_pkg::WID_X16, rpc_pkg::WID_X8, rpc_pkg::WID_X4};
  logic [31:0] regRdData;
  logic regRdValid, rspTimeoutEn;
  logic [3:0] rdHold, spreadEn;
  logic [2:0] pacingHome;
  logic [10:0] rspLimitMs;
  int errTotal = 0;
  int comparisons = 0;
  int msTab[10] = '{0, 5, 10, 15, 100, 200, 300, 500, 1000, 2000};
  int thr[3] = '{3, 2, 1};
  logic [3:0] upTab[5] = '{4'h8, 4'ha, 4'h2, 4'h0, 4'h0};
  logic ntTab[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [2:0] homeTab[5] = '{3'h3, 3'h3, 3'h1, rpc_pkg::HOME_NT, 3'h0};

  rpc_regs DUT (.core_clk(coreClk), .rst_n(rstN), .regWrEn(regWrEn),
    .regWrFromEe(regWrFromEe), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .portUpstreamPin(portUpstreamPin),
    .port0LegacyNtPin(port0LegacyNtPin), .selfUpstreamPin(selfUpstreamPin),
    .capLoad(capLoad), .capBus(capBus), .capDev(capDev), .rdIssue(rdIssue),
    .cplReturn(cplReturn), .linkWidth(linkWidth), .regRdData(regRdData),
    .regRdValid(regRdValid), .rdHold(rdHold), .spreadEn(spreadEn),
    .pacingHome(pacingHome), .rspTimeoutEn(rspTimeoutEn), .rspLimitMs(rspLimitMs));

  always #5 coreClk = ~coreClk;

  task automatic tally_and_finish();
    if (errTotal == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkOut(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chkOut

  task automatic wrReg(input logic [11:0] a, input logic [31:0] d, input logic ee);
    @(posedge coreClk);
    regWrEn <= 1'b1;
    regWrFromEe <= ee;
    regAddr <= a;
    regWrData <= d;
    @(posedge coreClk);
    regWrEn <= 1'b0;
    regWrFromEe <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [11:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge coreClk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge coreClk);
    regRdEn <= 1'b0;
    #1;
    while (regRdValid !== 1'b1 && n < 4) begin
      @(posedge coreClk);
      #1;
      n++;
    end
    // A missing answer counts once and the run carries on to the closing verdict
    if (regRdValid !== 1'b1) chkReg({31'h0000_0000, regRdValid}, 32'h0000_0001);
    else chkReg(regRdData, exp);
  endtask : rdReg

  task automatic pulse(input logic [3:0] iss, input logic [3:0] cpl);
    @(posedge coreClk);
    rdIssue <= iss;
    cplReturn <= cpl;
    @(posedge coreClk);
    rdIssue <= 4'h0;
    cplReturn <= 4'h0;
    #1;
  endtask : pulse

  task automatic settle(input int n);
    repeat (n) @(posedge coreClk);
    #1;
  endtask : settle

  initial begin
    settle(3);
    chkOut({5'h00, rspLimitMs}, 16'h0005);
    chkOut({4'h0, rdHold, spreadEn, pacingHome, rspTimeoutEn}, 16'h0001);
    @(posedge coreClk);
    rstN <= 1'b1;
    settle(3);
    rdReg(rpc_pkg::OFF_CTRL, 32'h0000_000f);
    rdReg(rpc_pkg::OFF_THR1, 32'h0600_0800);
    rdReg(rpc_pkg::OFF_THR2, 32'h0100_0400);
    rdReg(rpc_pkg::OFF_CAP, 32'h0000_0000);
    rdReg(12'h1e0, 32'h0000_0000);
    chkOut({12'h000, spreadEn}, 16'h0000);
    wrReg(rpc_pkg::OFF_CTRL, 32'hffff_ffff, 1'b0);
    rdReg(rpc_pkg::OFF_CTRL, 32'h000f_000f);
    // Port 3 paced off with spread allowed and port 1 spread disabled, so only ports 0 and 2 spread
    wrReg(rpc_pkg::OFF_CTRL, 32'h0002_0008, 1'b1);
    settle(2);
    chkOut({12'h000, spreadEn}, 16'h0005);
    wrReg(rpc_pkg::OFF_CTRL, 32'h0000_0000, 1'b0);
    wrReg(rpc_pkg::OFF_THR1, 32'hffff_ffff, 1'b0);
    rdReg(rpc_pkg::OFF_THR1, 32'h1fff_1fff);
    wrReg(rpc_pkg::OFF_THR2, 32'hffff_ffff, 1'b0);
    rdReg(rpc_pkg::OFF_THR2, 32'h0f00_1fff);
    settle(2);
    chkOut({15'h0000, rspTimeoutEn}, 16'h0000);
    for (int c = 0; c < 10; c++) begin
      wrReg(rpc_pkg::OFF_THR2, {4'h0, 4'(c), 24'h00_0003}, 1'b0);
      settle(2);
      chkOut({15'h0000, rspTimeoutEn}, {15'h0000, c != 0});
      if (c != 0) chkOut({5'h00, rspLimitMs}, 16'(msTab[c]));
    end
    wrReg(rpc_pkg::OFF_THR1, 32'h0002_0001, 1'b0);
    for (int p = 0; p < 3; p++) begin
      for (int k = 1; k < 4; k++) begin
        pulse(4'h1 << p, 4'h0);
        chkOut({15'h0000, rdHold[p]}, {15'h0000, k >= thr[p]});
      end
    end
    pulse(4'h0, 4'h1);
    chkOut({12'h000, rdHold}, 16'h0006);
    pulse(4'h1, 4'h1);
    chkOut({12'h000, rdHold}, 16'h0006);
    pulse(4'h1, 4'h0);
    chkOut({12'h000, rdHold}, 16'h0007);
    wrReg(rpc_pkg::OFF_THR2, 32'h0901_0003, 1'b1);
    rdReg(rpc_pkg::OFF_THR2, 32'h0900_0003);
    chkOut({12'h000, rdHold}, 16'h0006);
    wrReg(rpc_pkg::OFF_CTRL, 32'h0000_0002, 1'b0);
    settle(2);
    chkOut({12'h000, rdHold}, 16'h0004);
    wrReg(rpc_pkg::OFF_CAP, 32'h0000_1f55, 1'b0);
    rdReg(rpc_pkg::OFF_CAP, 32'h0000_0000);
    wrReg(rpc_pkg::OFF_CAP, 32'h8000_1f55, 1'b0);
    rdReg(rpc_pkg::OFF_CAP, 32'h8000_0000);
    wrReg(rpc_pkg::OFF_CAP, 32'h8000_1f55, 1'b0);
    rdReg(rpc_pkg::OFF_CAP, 32'h8000_0055);
    @(posedge coreClk);
    selfUpstreamPin <= 1'b1;
    settle(4);
    wrReg(rpc_pkg::OFF_CAP, 32'h8000_1f55, 1'b0);
    rdReg(rpc_pkg::OFF_CAP, 32'h8000_1f55);
    @(posedge coreClk);
    capLoad <= 1'b1;
    @(posedge coreClk);
    capLoad <= 1'b0;
    rdReg(rpc_pkg::OFF_CAP, 32'h8000_0aa5);
    // Second reset in mid-run must bring the hold, spread, home and timeout-enable outputs and the control and capture registers back to their defaults
    @(posedge coreClk);
    rstN <= 1'b0;
    settle(2);
    chkOut({4'h0, rdHold, spreadEn, pacingHome, rspTimeoutEn}, 16'h0001);
    @(posedge coreClk);
    rstN <= 1'b1;
    settle(3);
    rdReg(rpc_pkg::OFF_CTRL, 32'h0000_000f);
    rdReg(rpc_pkg::OFF_CAP, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      @(posedge coreClk);
      portUpstreamPin <= upTab[i];
      port0LegacyNtPin <= ntTab[i];
      settle(5);
      chkOut({13'h0000, pacingHome}, {13'h0000, homeTab[i]});
    end
    tally_and_finish();
  end
endmodule : test_read_pacing_control_regs
